// file: msx_csr_rx.sv
// Control/status word, receive silo and transmit scanner of the multiplexer
`timescale 1ns/10ps
module msx_csr_rx import msx_pkg::*; (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        bus_init,
    // Host register port
    input  wire logic        host_rd,
    input  wire logic        host_wr,
    input  wire logic        host_receive_buffer_word_sel,
    input  wire logic [15:0] host_wdata,
    output logic [15:0]      host_rdata_ff,
    output logic             host_rack_ff,
    // Line parameter write strobe
    output logic             line_param_wr_ff,
    output logic [15:0]      line_param_word_ff,
    // Received characters from the line receivers
    input  wire logic        rx_in_valid,
    output logic             rx_in_ready,
    input  wire logic [7:0]  rx_in_char,
    input  wire logic [1:0]  rx_in_len,
    input  wire logic [2:0]  rx_in_line,
    input  wire logic        rx_in_perr,
    input  wire logic        rx_in_ferr,
    input  wire logic        rx_in_ovrn,
    // Serial turnaround
    input  wire logic [7:0]  tx_serial,
    input  wire logic [7:0]  rx_serial_pin,
    output logic [7:0]       rx_serial_to_uart_ff,
    output logic             loopback_turnaround_ff,
    // Transmit scanner inputs
    input  wire logic [7:0]  tx_buf_empty,
    input  wire logic [7:0]  line_transmit_enable,
    input  wire logic        tx_buf_load,
    // Status to the rest of the device
    output logic             scan_enable_ff,
    output logic             soft_clear_pulse_ff,
    output logic             rx_interrupt_request_ff,
    output logic             tx_irq_request_ff
);
    // Control bits
    logic                  rie_ff;         // Receiver interrupt enable
    logic                  sae_ff;         // Silo alarm enable
    logic                  tie_ff;         // Transmit interrupt enable
    logic                  tx_line_ready;  // Transmitter ready
    logic [2:0]            tx_ready_line_number_ff;       // Ready line number
    logic                  sa_ff;          // Silo alarm flag
    // Soft clear sequencer
    msx_clr_state_t        state_ff;
    msx_clr_state_t        nxt_state;
    logic [10:0]           clr_cnt_ff;
    // Silo storage
    logic [ENTRY_W-1:0]    silo_mem [SILO_DEPTH];
    logic [5:0]            wr_ptr_ff;
    logic [5:0]            rd_ptr_ff;
    logic [6:0]            silo_cnt_ff;
    logic [4:0]            alarm_cnt_ff;   // Entries since last alarm
    logic [14:0]           last_low_ff;    // Last presented low bits
    // Scanner
    logic [7:0]            scan_div_ff;
    logic [2:0]            scan_ptr_ff;

    // Decoded wires
    logic                  clr_busy;
    logic                  clear_all;
    logic                  csr_wr;
    logic                  receive_buffer_word_rd;
    logic                  clr_start;
    logic                  silo_flush;
    logic                  push;
    logic                  pop;
    logic                  rx_char_available;
    logic                  scan_tick;
    logic                  line_ok;
    logic                  tx_line_ready_set;
    logic                  alarm_hit;
    logic                  fifo_valid;
    logic                  fifo_ready;
    logic [ENTRY_W-1:0]    in_entry;
    logic [ENTRY_W-1:0]    fifo_entry;
    logic [ENTRY_W-1:0]    head_entry;
    logic [7:0]            char_mask;
    logic [15:0]           csr_word;
    logic [15:0]           receive_buffer_word_word;
    logic                  rx_irq;

    // Reset sources and host decode
    assign clr_busy   = (state_ff == ST_CLEAR);
    assign clear_all  = bus_init | clr_busy;
    assign csr_wr     = host_wr & ~host_receive_buffer_word_sel & ~clear_all;
    assign receive_buffer_word_rd    = host_rd & host_receive_buffer_word_sel;
    assign clr_start  = csr_wr & host_wdata[CSR_CLR_BIT];
    assign silo_flush = clear_all | ~scan_enable_ff;

    // Character mask for shorter codes
    assign char_mask  = 8'hFF >> (2'h3 - rx_in_len);
    assign in_entry   = {rx_in_ovrn, rx_in_ferr, rx_in_perr,
                         1'b0, rx_in_line,
                         rx_in_char & char_mask};

    // Silo movement
    assign fifo_ready = scan_enable_ff & ~clear_all
                      & (silo_cnt_ff != SILO_FULL);
    assign push       = fifo_valid & fifo_ready;
    assign pop        = receive_buffer_word_rd & (silo_cnt_ff != 7'h00);
    assign head_entry = silo_mem[rd_ptr_ff];
    assign rx_char_available      = (silo_cnt_ff != 7'h00);
    assign alarm_hit  = push & sae_ff
                      & (alarm_cnt_ff == ALARM_LAST);

    // Transmit scanner decode
    assign scan_tick  = (scan_div_ff == SCAN_LAST);
    assign line_ok    = tx_buf_empty[scan_ptr_ff]
                      & line_transmit_enable[scan_ptr_ff];
    assign tx_line_ready_set   = scan_tick & line_ok & scan_enable_ff
                      & ~tx_line_ready & ~clear_all;

    // Register read words, unused bits zero
    assign csr_word   = {tx_line_ready, tie_ff, sa_ff, sae_ff, 1'b0,
                         tx_ready_line_number_ff, rx_char_available, rie_ff, scan_enable_ff,
                         clr_busy, loopback_turnaround_ff,
                         3'b000};
    assign receive_buffer_word_word  = {rx_char_available,
                         rx_char_available ? head_entry : last_low_ff};
    assign rx_irq     = rie_ff & (sae_ff ? sa_ff : rx_char_available);

    // Soft clear sequencer next state
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_RUN: begin
                if (clr_start) begin
                    nxt_state = ST_CLEAR;
                end
            end
            ST_CLEAR: begin
                if (clr_cnt_ff == CLR_LAST) begin
                    nxt_state = ST_RUN;
                end
            end
            default: nxt_state = ST_RUN;
        endcase
    end

    // Input staging buffer ahead of the silo
    msx_skid2 #(
        .W           (ENTRY_W)
    ) u_stage (
        .ref_clk     (ref_clk),
        .sys_rst     (sys_rst),
        .flush       (silo_flush),
        .in_valid    (rx_in_valid),
        .in_ready_ff (rx_in_ready),
        .in_data     (in_entry),
        .out_valid   (fifo_valid),
        .out_ready   (fifo_ready),
        .out_data    (fifo_entry)
    );

    // Soft clear state and duration counter
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff   <= ST_RUN;
            clr_cnt_ff <= 11'h000;
        end else begin
            state_ff   <= nxt_state;
            clr_cnt_ff <= clr_busy ? 11'(clr_cnt_ff + 11'h001) : 11'h000;
        end
    end

    // Writable control bits, cleared by either reset
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            loopback_turnaround_ff <= CSR_RESET[CSR_LOOP_BIT];
            scan_enable_ff         <= CSR_RESET[CSR_MSE_BIT];
            rie_ff                 <= CSR_RESET[CSR_RIE_BIT];
            sae_ff                 <= CSR_RESET[CSR_SAE_BIT];
            tie_ff                 <= CSR_RESET[CSR_TIE_BIT];
        end else if (clear_all) begin
            loopback_turnaround_ff <= 1'b0;
            scan_enable_ff         <= 1'b0;
            rie_ff                 <= 1'b0;
            sae_ff                 <= 1'b0;
            tie_ff                 <= 1'b0;
        end else if (csr_wr && !clr_start) begin
            loopback_turnaround_ff <= host_wdata[CSR_LOOP_BIT];
            scan_enable_ff         <= host_wdata[CSR_MSE_BIT];
            rie_ff                 <= host_wdata[CSR_RIE_BIT];
            sae_ff                 <= host_wdata[CSR_SAE_BIT];
            tie_ff                 <= host_wdata[CSR_TIE_BIT];
        end
    end

    // Silo storage, written on push
    always_ff @(posedge ref_clk) begin
        if (push) begin
            silo_mem[wr_ptr_ff] <= fifo_entry;
        end
    end

    // Silo pointers and fill count
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr_ff   <= 6'h00;
            rd_ptr_ff   <= 6'h00;
            silo_cnt_ff <= 7'h00;
        end else if (silo_flush) begin
            wr_ptr_ff   <= 6'h00;
            rd_ptr_ff   <= 6'h00;
            silo_cnt_ff <= 7'h00;
        end else begin
            wr_ptr_ff   <= 6'(wr_ptr_ff + {5'h00, push});
            rd_ptr_ff   <= 6'(rd_ptr_ff + {5'h00, pop});
            silo_cnt_ff <= 7'(silo_cnt_ff + {6'h00, push}
                              - {6'h00, pop});
        end
    end

    // Last presented low bits survive bus initialize and soft clear
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            last_low_ff <= RB_LOW_RESET;
        end else if (pop) begin
            last_low_ff <= head_entry;
        end
    end

    // Silo alarm counter and flag, set wins over read
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            alarm_cnt_ff <= 5'h00;
            sa_ff        <= CSR_RESET[CSR_SA_BIT];
        end else if (silo_flush) begin
            alarm_cnt_ff <= 5'h00;
            sa_ff        <= clear_all ? 1'b0 : sa_ff & ~receive_buffer_word_rd;
        end else begin
            if (alarm_hit) begin
                alarm_cnt_ff <= 5'h00;
            end else if (push && sae_ff) begin
                alarm_cnt_ff <= 5'(alarm_cnt_ff + 5'h01);
            end
            sa_ff <= alarm_hit | (sa_ff & ~receive_buffer_word_rd);
        end
    end

    // Scanner divider, restarted after a transmit load
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            scan_div_ff <= 8'h00;
            scan_ptr_ff <= 3'h0;
        end else if (clear_all || tx_buf_load || scan_tick) begin
            scan_div_ff <= 8'h00;
            scan_ptr_ff <= clear_all ? 3'h0
                         : 3'(scan_ptr_ff + {2'h0, scan_tick});
        end else begin
            scan_div_ff <= 8'(scan_div_ff + 8'h01);
        end
    end

    // Transmitter ready flag and its line number
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_line_ready <= CSR_RESET[CSR_TX_LINE_READY_BIT];
            tx_ready_line_number_ff      <= 3'h0;
        end else if (clear_all) begin
            tx_line_ready <= 1'b0;
            tx_ready_line_number_ff      <= 3'h0;
        end else if (tx_line_ready_set) begin
            tx_line_ready <= 1'b1;
            tx_ready_line_number_ff      <= scan_ptr_ff;
        end else if (tx_buf_load) begin
            tx_line_ready <= 1'b0;
        end
    end

    // Host answers and registered outputs
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            host_rdata_ff           <= 16'h0000;
            host_rack_ff            <= 1'b0;
            line_param_wr_ff        <= 1'b0;
            line_param_word_ff      <= 16'h0000;
            rx_serial_to_uart_ff    <= SERIAL_IDLE;
            soft_clear_pulse_ff     <= 1'b0;
            rx_interrupt_request_ff <= 1'b0;
            tx_irq_request_ff       <= 1'b0;
        end else begin
            host_rack_ff       <= host_rd;
            host_rdata_ff      <= !host_rd ? 16'h0000
                                : host_receive_buffer_word_sel ? receive_buffer_word_word : csr_word;
            line_param_wr_ff   <= host_wr & host_receive_buffer_word_sel;
            if (host_wr && host_receive_buffer_word_sel) begin
                line_param_word_ff <= host_wdata;
            end
            rx_serial_to_uart_ff <= loopback_turnaround_ff
                                  ? tx_serial : rx_serial_pin;
            soft_clear_pulse_ff     <= bus_init
                                     | (nxt_state == ST_CLEAR);
            rx_interrupt_request_ff <= rx_irq;
            tx_irq_request_ff <= tie_ff & tx_line_ready;
        end
    end

    // Checks on the block's own behaviour
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    clr_length_a: assert property ($fell(clr_busy) |->
        $past(clr_cnt_ff) == CLR_LAST)
        else $error("soft clear length wrong");
    clr_resets_a: assert property (clr_busy |=>
        !scan_enable_ff && !rie_ff && !sae_ff && tx_ready_line_number_ff == 3'h0)
        else $error("soft clear left control bits set");
    loop_route_a: assert property (loopback_turnaround_ff |=>
        rx_serial_to_uart_ff == $past(tx_serial))
        else $error("loopback not routed");
    mse_empty_a: assert property (!scan_enable_ff |=>
        silo_cnt_ff == 7'h00 && !rx_char_available)
        else $error("silo not empty without scan");
    pop_step_a: assert property (pop && !push && !silo_flush
        |=> silo_cnt_ff == $past(silo_cnt_ff) - 7'h01)
        else $error("read did not pop silo");
    empty_valid_a: assert property (receive_buffer_word_rd && !rx_char_available |=>
        !host_rdata_ff[RB_VALID_BIT] && host_rack_ff)
        else $error("empty silo read as valid");
    alarm_count_a: assert property ($rose(sa_ff) |->
        $past(push) && $past(alarm_cnt_ff) == ALARM_LAST)
        else $error("alarm not at sixteenth entry");
    sae_mute_a: assert property (sae_ff && !sa_ff && rie_ff
        |=> !rx_interrupt_request_ff)
        else $error("receive-done interrupt not muted");
    load_gap_a: assert property (tx_buf_load && !clear_all
        |=> !tx_line_ready [*8])
        else $error("ready line returned too soon");
    tx_irq_a: assert property (tie_ff && tx_line_ready
        |=> tx_irq_request_ff)
        else $error("transmit interrupt missing");

    alarm_fire_c: cover property ($rose(sa_ff));
    clear_run_c:  cover property ($fell(clr_busy));
    tx_line_ready_load_c:  cover property (tx_line_ready ##1 tx_buf_load);
    silo_full_c:  cover property (silo_cnt_ff == SILO_FULL);
endmodule : msx_csr_rx

// file: msx_host_model.sv
// Host processor model driving the register port
`timescale 1ns/10ps
module msx_host_model (
    // Clock
    input  wire logic        ref_clk,
    // Register port towards the device
    output logic             host_rd,
    output logic             host_wr,
    output logic             host_receive_buffer_word_sel,
    output logic [15:0]      host_wdata,
    input  wire logic [15:0] host_rdata_ff,
    input  wire logic        host_rack_ff
);
    // Bus idle at time zero
    initial begin
        {host_rd, host_wr, host_receive_buffer_word_sel} = 3'b000;
        host_wdata = 16'h0000;
    end
    // One-cycle write strobe, data scrambled once released
    task automatic bus_write(input logic s, input logic [15:0] d);
        @(negedge ref_clk);
        {host_receive_buffer_word_sel, host_wdata, host_wr} = {s, d, 1'b1};
        @(negedge ref_clk);
        host_wr = 1'b0;
        host_wdata = ~d;
    endtask : bus_write
    // Full-word read pulse only, answer taken one cycle later
    task automatic bus_read(input logic s, output logic [15:0] d,
                            output logic ok);
        @(negedge ref_clk);
        {host_receive_buffer_word_sel, host_rd} = {s, 1'b1};
        @(negedge ref_clk);
        host_rd = 1'b0;
        {d, ok} = {host_rdata_ff, host_rack_ff};
    endtask : bus_read
endmodule : msx_host_model

// file: msx_pkg.sv
// Shared constants for the serial multiplexer control and receive silo
package msx_pkg;
    // Control/status word field positions
    localparam int CSR_LOOP_BIT  = 3;
    localparam int CSR_CLR_BIT   = 4;
    localparam int CSR_MSE_BIT   = 5;
    localparam int CSR_RIE_BIT   = 6;
    localparam int CSR_RX_CHAR_AVAILABLE_BIT = 7;
    localparam int CSR_TX_READY_LINE_NUMBER_LSB = 8;
    localparam int CSR_SAE_BIT   = 12;
    localparam int CSR_SA_BIT    = 13;
    localparam int CSR_TIE_BIT   = 14;
    localparam int CSR_TX_LINE_READY_BIT  = 15;
    // Receive buffer word field positions
    localparam int RB_LINE_LSB   = 8;
    localparam int RB_PERR_BIT   = 12;
    localparam int RB_FERR_BIT   = 13;
    localparam int RB_OVRN_BIT   = 14;
    localparam int RB_VALID_BIT  = 15;
    // Reset values
    localparam logic [15:0] CSR_RESET    = 16'h0000;
    localparam logic [14:0] RB_LOW_RESET = 15'h0000;
    localparam logic [7:0]  SERIAL_IDLE  = 8'hFF;
    // Timing, clock period and documented times in picoseconds
    localparam int CLK_PERIOD_PS = 10000;
    localparam int CLR_TIME_PS   = 15000000;
    localparam int TX_READY_LINE_NUMBER_GAP_PS  = 1900000;
    localparam int CLR_CYCLES    =
        (CLR_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SCAN_CYCLES   =
        (TX_READY_LINE_NUMBER_GAP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [10:0] CLR_LAST  = 11'(CLR_CYCLES - 1);
    localparam logic [7:0]  SCAN_LAST = 8'(SCAN_CYCLES - 1);
    // Silo sizing
    localparam int          SILO_DEPTH  = 64;
    localparam logic [6:0]  SILO_FULL   = 7'h40;
    localparam logic [4:0]  ALARM_LAST  = 5'h0F;
    localparam int          ENTRY_W     = 15;
    // Soft clear sequencer states
    typedef enum logic [1:0] {
        ST_RUN   = 2'b01,
        ST_CLEAR = 2'b10
    } msx_clr_state_t;
endpackage : msx_pkg

// file: msx_skid2.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
module msx_skid2 import msx_pkg::*; #(
    parameter int W = ENTRY_W
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         sys_rst,
    input  wire logic         flush,
    // Fill side
    input  wire logic         in_valid,
    output logic              in_ready_ff,
    input  wire logic [W-1:0] in_data,
    // Drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    logic [W-1:0] slot_ff [2];  // Two storage slots
    logic         wr_sel_ff;    // Slot written next
    logic         rd_sel_ff;    // Slot read next
    logic [1:0]   cnt_ff;       // Entries held
    logic [1:0]   nxt_cnt;
    logic         take;
    logic         give;

    assign take      = in_valid & in_ready_ff & ~flush;
    assign give      = out_valid & out_ready;
    assign out_valid = (cnt_ff != 2'h0) & ~flush;
    assign out_data  = slot_ff[rd_sel_ff];
    assign nxt_cnt   = flush ? 2'h0
                     : 2'(cnt_ff + {1'b0, take} - {1'b0, give});

    // Slot storage, no reset needed
    always_ff @(posedge ref_clk) begin
        if (take) begin
            slot_ff[wr_sel_ff] <= in_data;
        end
    end

    // Pointers, count and registered ready
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_sel_ff   <= 1'b0;
            rd_sel_ff   <= 1'b0;
            cnt_ff      <= 2'h0;
            in_ready_ff <= 1'b1;
        end else begin
            wr_sel_ff   <= flush ? 1'b0 : wr_sel_ff ^ take;
            rd_sel_ff   <= flush ? 1'b0 : rd_sel_ff ^ give;
            cnt_ff      <= nxt_cnt;
            in_ready_ff <= (nxt_cnt != 2'h2);
        end
    end
endmodule : msx_skid2

// file: multiline_serial_csr_rx_silo_bench.sv
// Self-checking bench for the control word and receive silo
`timescale 1ns/10ps
module multiline_serial_csr_rx_silo_bench import msx_pkg::*; ;
    // Stimulus and observed signals
    logic        ref_clk, sys_rst, bus_init, host_rd, host_wr, host_receive_buffer_word_sel;
    logic        host_rack_ff, line_param_wr_ff, rx_in_valid, rx_in_ready;
    logic        rx_in_perr, rx_in_ferr, rx_in_ovrn, tx_buf_load;
    logic        loopback_turnaround_ff, scan_enable_ff, soft_clear_pulse_ff;
    logic        rx_interrupt_request_ff, tx_irq_request_ff;
    logic [15:0] host_wdata, host_rdata_ff, line_param_word_ff, rd_d;
    logic [7:0]  rx_in_char, tx_serial, rx_serial_pin, rx_serial_to_uart_ff;
    logic [7:0]  tx_buf_empty, line_transmit_enable;
    logic [2:0]  rx_in_line;
    logic [1:0]  rx_in_len;
    int          mismatches, total_checks;
    // Design and host model
    msx_csr_rx msx_csr_rx_inst (.ref_clk, .sys_rst, .bus_init, .host_rd,
        .host_wr, .host_receive_buffer_word_sel, .host_wdata, .host_rdata_ff, .host_rack_ff,
        .line_param_wr_ff, .line_param_word_ff, .rx_in_valid, .rx_in_ready,
        .rx_in_char, .rx_in_len, .rx_in_line, .rx_in_perr, .rx_in_ferr,
        .rx_in_ovrn, .tx_serial, .rx_serial_pin, .rx_serial_to_uart_ff,
        .loopback_turnaround_ff, .tx_buf_empty, .line_transmit_enable,
        .tx_buf_load, .scan_enable_ff, .soft_clear_pulse_ff,
        .rx_interrupt_request_ff, .tx_irq_request_ff);
    msx_host_model msx_host_model_inst (.ref_clk, .host_rd, .host_wr,
        .host_receive_buffer_word_sel, .host_wdata, .host_rdata_ff, .host_rack_ff);
    // 100 MHz clock
    always #5 ref_clk = ~ref_clk;
    // Compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Counts, verdict, end of run
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report
    // Exhausted wait ends the run
    task automatic bound(input int i, input int n);
        if (i == n) begin
            mismatches++;
            final_report();
        end
    endtask : bound
    // Idle cycles
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc
    // Control word write
    task automatic csr(input logic [15:0] d);
        msx_host_model_inst.bus_write(1'b0, d);
    endtask : csr
    // Read with answer and value check
    task automatic rdx(input logic s, input logic [15:0] exp);
        logic ok;
        msx_host_model_inst.bus_read(s, rd_d, ok);
        chk({15'h0, ok}, 16'h0001);
        chk(rd_d, exp);
    endtask : rdx
    // Offer one character, held until taken
    task automatic push(input logic [2:0] ln, input logic [7:0] ch,
                        input logic [1:0] len, input logic [2:0] err);
        int i;
        @(negedge ref_clk);
        {rx_in_line, rx_in_char, rx_in_len} = {ln, ch, len};
        {rx_in_ovrn, rx_in_ferr, rx_in_perr} = err;
        rx_in_valid = 1'b1;
        for (i = 0; i < 50 && rx_in_ready !== 1'b1; i++) cyc(1);
        bound(i, 50);
        @(negedge ref_clk);
        rx_in_valid = 1'b0;
        rx_in_char = ~ch;
    endtask : push
    // Wait for transmitter interrupt request
    task automatic wait_tirq();
        int i;
        for (i = 0; i < 3000 && tx_irq_request_ff !== 1'b1; i++) cyc(1);
        bound(i, 3000);
    endtask : wait_tirq
    // Reset values, writable bits, loopback, shared address write
    task automatic t_regs();
        rdx(1'b0, CSR_RESET);
        rdx(1'b1, {1'b0, RB_LOW_RESET});
        csr(16'hFFEF);
        rdx(1'b0, 16'h5068);
        chk({14'h0, loopback_turnaround_ff, scan_enable_ff}, 16'h0003);
        cyc(3);
        chk({8'h0, rx_serial_to_uart_ff}, 16'h00A5);
        csr(16'h0000);
        cyc(3);
        chk({8'h0, rx_serial_to_uart_ff}, 16'h003C);
        msx_host_model_inst.bus_write(1'b1, 16'h1234);
        chk({line_param_wr_ff, 15'h0}, 16'h8000);
        chk(line_param_word_ff, 16'h1234);
        $display("test regs done");
    endtask : t_regs
    // Characters with lengths and error flags, drained in order
    task automatic t_rx();
        csr(16'h0060);
        push(3'd3, 8'hFF, 2'b00, 3'b001);
        push(3'd7, 8'hC4, 2'b11, 3'b100);
        push(3'd1, 8'hFF, 2'b10, 3'b010);
        cyc(4);
        rdx(1'b0, 16'h00E0);
        chk({15'h0, rx_interrupt_request_ff}, 16'h0001);
        rdx(1'b1, 16'h931F);
        rdx(1'b1, 16'hC7C4);
        rdx(1'b1, 16'hA17F);
        rdx(1'b1, 16'h217F);
        rdx(1'b0, 16'h0060);
        $display("test receive done");
    endtask : t_rx
    // Alarm after sixteen entries, cleared by a buffer read
    task automatic t_alarm();
        int i;
        csr(16'h1060);
        for (i = 0; i < 15; i++) push(3'd0, 8'(i), 2'b11, 3'b000);
        cyc(4);
        rdx(1'b0, 16'h10E0);
        chk({15'h0, rx_interrupt_request_ff}, 16'h0000);
        push(3'd0, 8'h0F, 2'b11, 3'b000);
        cyc(4);
        rdx(1'b0, 16'h30E0);
        chk({15'h0, rx_interrupt_request_ff}, 16'h0001);
        for (i = 0; i < 16; i++) rdx(1'b1, 16'h8000 | 16'(i));
        rdx(1'b0, 16'h1060);
        rdx(1'b1, 16'h000F);
        $display("test alarm done");
    endtask : t_alarm
    // Scanner reports ready lines, load clears ready
    task automatic t_tx();
        {tx_buf_empty, line_transmit_enable} = {8'h20, 8'h20};
        csr(16'h4020);
        wait_tirq();
        rdx(1'b0, 16'hC520);
        {tx_buf_load, tx_buf_empty, line_transmit_enable} = {1'b1, 16'h0424};
        cyc(1);
        tx_buf_load = 1'b0;
        cyc(2);
        chk({15'h0, tx_irq_request_ff}, 16'h0000);
        wait_tirq();
        rdx(1'b0, 16'hC220);
        $display("test transmit done");
    endtask : t_tx
    // Timed soft clear keeps stale buffer bits
    task automatic t_clear();
        push(3'd2, 8'h55, 2'b11, 3'b000);
        cyc(4);
        csr(16'h0010);
        rdx(1'b0, 16'h0010);
        chk({15'h0, soft_clear_pulse_ff}, 16'h0001);
        cyc(1500);
        rdx(1'b0, CSR_RESET);
        rdx(1'b1, 16'h000F);
        $display("test clear done");
    endtask : t_clear
    // Bus initialize empties the silo and clears control bits
    task automatic t_init();
        csr(16'h1068);
        push(3'd4, 8'h3A, 2'b11, 3'b000);
        cyc(4);
        rdx(1'b1, 16'h843A);
        push(3'd6, 8'h81, 2'b11, 3'b000);
        cyc(4);
        bus_init = 1'b1;
        cyc(2);
        chk({15'h0, soft_clear_pulse_ff}, 16'h0001);
        bus_init = 1'b0;
        rdx(1'b0, CSR_RESET);
        chk({14'h0, loopback_turnaround_ff, scan_enable_ff}, 16'h0000);
        rdx(1'b1, 16'h043A);
        $display("test init done");
    endtask : t_init
    // Main sequence
    initial begin
        {ref_clk, sys_rst, bus_init, tx_buf_load, rx_in_valid} = 5'b01000;
        {rx_in_perr, rx_in_ferr, rx_in_ovrn, rx_in_line} = 6'h00;
        {rx_in_char, rx_in_len, tx_serial, rx_serial_pin} = 26'h0;
        tx_serial = 8'hA5;
        rx_serial_pin = 8'h3C;
        {tx_buf_empty, line_transmit_enable} = 16'h0000;
        {mismatches, total_checks} = {32'd0, 32'd0};
        cyc(20);
        sys_rst = 1'b0;
        t_regs();
        t_rx();
        t_alarm();
        t_tx();
        t_clear();
        t_init();
        final_report();
    end
endmodule : multiline_serial_csr_rx_silo_bench
